// ### pkg/dtt_pkg.sv
package dtt_pkg;
  // Register word indices; the byte address is four times the index.
  localparam int unsigned DTT_NUM_REGS   = 11;
  localparam logic [3:0]  DTT_IDX_ADDR   = 4'h0;
  localparam logic [3:0]  DTT_IDX_AMASK  = 4'h1;
  localparam logic [3:0]  DTT_IDX_DATA   = 4'h2;
  localparam logic [3:0]  DTT_IDX_DMASK  = 4'h3;
  localparam logic [3:0]  DTT_IDX_PC0    = 4'h4;
  localparam logic [3:0]  DTT_IDX_PC3    = 4'h7;
  localparam logic [3:0]  DTT_IDX_PMASK  = 4'h8;
  localparam logic [3:0]  DTT_IDX_CTRL   = 4'h9;
  localparam logic [3:0]  DTT_IDX_STAT   = 4'ha;
  // Trigger control fields.
  localparam int unsigned DTT_CTL_PC_EN  = 0;
  localparam int unsigned DTT_CTL_AD_EN  = 1;
  localparam int unsigned DTT_CTL_DA_EN  = 2;
  localparam int unsigned DTT_CTL_TWO_LV = 3;
  localparam int unsigned DTT_CTL_ACTION = 4;
  localparam int unsigned DTT_CTL_ARM    = 5;
  localparam int unsigned DTT_CTL_CRIT_L = 8;
  localparam int unsigned DTT_CTL_CRIT_W = 3;
  // Status fields; writing a one clears the flag.
  localparam int unsigned DTT_ST_LEVEL1  = 0;
  localparam int unsigned DTT_ST_FIRED   = 1;
  localparam int unsigned DTT_ST_HALTED  = 2;
  // Reset values.
  localparam logic [31:0] DTT_RST_WORD   = 32'h0000_0000;
  localparam logic [31:0] DTT_RST_MASK   = 32'hffff_ffff;
  localparam logic [31:0] DTT_CTRL_RST   = 32'h0000_0700;
  // Halted status code on the processor status bus.
  localparam logic [3:0]  DTT_PST_HALT   = 4'hf;
  // Serial frame: write flag, 4-bit index, 32-bit data.
  localparam int unsigned DTT_FRAME_BITS = 37;
  localparam int unsigned DTT_NIBBLES    = 8;
  // Serial command decode.
  typedef enum logic {DTT_CMD_READ, DTT_CMD_WRITE} dtt_cmd_t;
endpackage

// ### rtl/dtt_debug_unit.sv
// What this block does
// [R01] Nine 32-bit breakpoint registers with masks.
// [R02] Registers reachable by serial and supervisor.
// [R03] Single-level or two-level ordered triggers.
// [R04] Trigger halts core or raises debug interrupt.
// [R05] Critical interrupts still serviced during debug.
// [R06] Drive status, trace data and trace clock.
// [R07] Combined output is AND of status bits.
// [R08] Trace buses only on large package option.
// [R09] Comparators ignore bits their mask clears.
//
// Added by the designer: the address map and the APB register port.
module dtt_debug_unit
  import dtt_pkg::*;
#(
  parameter bit FULL_TRACE = 1'b1,
  parameter int LEVEL_W    = 3
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  // APB slave for supervisor-mode software.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [5:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [2:0]         pprot,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Core observation inputs.
  input  wire logic               i_bus_valid,
  input  wire logic [31:0]        i_bus_addr,
  input  wire logic [31:0]        i_bus_data,
  input  wire logic               i_pc_valid,
  input  wire logic [31:0]        i_pc,
  input  wire logic [3:0]         i_cpu_status,
  input  wire logic               i_branch_valid,
  input  wire logic [31:0]        i_branch_target,
  input  wire logic               i_emu_mode,
  input  wire logic               i_irq_req,
  input  wire logic [LEVEL_W-1:0] i_irq_level,
  // Core control outputs.
  output logic                    o_halt_req,
  output logic                    o_debug_irq,
  output logic                    o_irq_allow,
  // Trace port.
  output logic      [3:0]         o_processor_status_bus,
  output logic      [3:0]         o_trace_data_bus,
  output logic                    o_trace_clock_out,
  output logic                    o_combined_halt_status,
  // Serial debug channel.
  input  wire logic               i_debug_serial_clock,
  input  wire logic               i_debug_serial_in,
  output logic                    o_debug_serial_out
);

  // Mask compare: only bits set in the mask take part.
  // A mask of all zeros makes that comparator match on every access.
  function automatic logic masked_hit(input logic [31:0] a, input logic [31:0] b,
                                      input logic [31:0] m);
    masked_hit = ((a ^ b) & m) == DTT_RST_WORD; // R09
  endfunction

  // Register decode, shared by the bus and the serial path.
  // Indices past the status word read as zero.
  function automatic logic [31:0] reg_read(input logic [3:0] idx,
                                           input logic [31:0] bank [9],
                                           input logic [31:0] ctl,
                                           input logic [31:0] st);
    if (idx <= DTT_IDX_PMASK) begin
      reg_read = bank[idx];
    end else if (idx == DTT_IDX_CTRL) begin
      reg_read = ctl;
    end else if (idx == DTT_IDX_STAT) begin
      reg_read = st;
    end else begin
      reg_read = DTT_RST_WORD;
    end
  endfunction

  logic [31:0] bp_ff [9];           // Breakpoint register bank.
  logic [31:0] ctrl_ff;             // Trigger control word.
  logic [2:0]  stat_ff;             // Level-one, fired and halted flags.
  logic [31:0] stat_word;           // Status as a readable word.
  logic        apb_ok;              // Privileged, mapped access.
  logic [3:0]  apb_idx;             // Word index of the bus address.
  logic        apb_wr;              // Bus write taking effect.
  logic        ser_wr;              // Serial write taking effect.
  logic [3:0]  wr_idx;              // Index of the write this cycle.
  logic [31:0] wr_val;              // Value of the write this cycle.
  logic        wr_en;               // Any write this cycle.
  logic        pc_hit;              // Any PC comparator matched.
  logic        ad_hit;              // Address comparator matched.
  logic        da_hit;              // Data comparator matched.
  logic        cond_hit;            // Enabled bus conditions all matched.
  logic        fire;                // Trigger fires this cycle.

  // The bus answers with no wait states, so pready is tied high. Read data
  // comes from the register loaded in the setup cycle, so a serial write that
  // lands between setup and access is not seen by that read.
  assign stat_word = {29'h0, stat_ff};
  assign apb_idx   = paddr[5:2];
  // Only supervisor accesses to a mapped word are honoured.
  assign apb_ok    = pprot[0] && (apb_idx <= DTT_IDX_STAT) && (paddr[1:0] == 2'h0); // R02
  assign apb_wr    = psel && penable && pwrite && apb_ok;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !apb_ok;

  // Bus read data comes from a flop loaded in the setup cycle.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      prdata <= DTT_RST_WORD;
    end else if (psel && !penable) begin
      prdata <= apb_ok ? reg_read(apb_idx, bp_ff, ctrl_ff, stat_word) : DTT_RST_WORD;
    end
  end

  // Serial channel, link side. This logic runs on the tool's clock, which
  // stands still between frames; the frame counter realigns only through reset.
  logic [1:0]  lrst_ff;             // Reset synchroniser on the link clock.
  logic [5:0]  bit_cnt_ff;          // Bit position within a frame.
  logic [36:0] sh_in_ff;            // Incoming command shift register.
  logic [36:0] cmd_hold_ff;         // Completed command, held for the crossing.
  logic        req_tgl_ff;          // Toggles once per completed command.
  logic [31:0] sh_out_ff;           // Outgoing response shift register.
  logic [31:0] resp_ff;             // Response word, system domain.

  // The link logic leaves reset two link edges after the system reset.
  // Only the second flop of this chain is read by the link logic.
  always_ff @(posedge i_debug_serial_clock) begin
    lrst_ff <= {lrst_ff[0], i_rst};
  end

  // Shift command bits in, most significant first, and hand off each frame.
  always_ff @(posedge i_debug_serial_clock) begin
    if (lrst_ff[1]) begin
      bit_cnt_ff  <= 6'h0;
      sh_in_ff    <= 37'h0;
      cmd_hold_ff <= 37'h0;
      req_tgl_ff  <= 1'b0;
    end else begin
      sh_in_ff <= {sh_in_ff[35:0], i_debug_serial_in};
      if (bit_cnt_ff == 6'(DTT_FRAME_BITS - 1)) begin
        bit_cnt_ff  <= 6'h0;
        cmd_hold_ff <= {sh_in_ff[35:0], i_debug_serial_in};
        req_tgl_ff  <= ~req_tgl_ff; // R02
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 6'h1;
      end
    end
  end

  // The previous response is loaded at the start of each frame. The word
  // crosses without a handshake, so the tool must leave a gap of several
  // system clocks after a frame before it clocks the next one; frames sent
  // back to back may pick up a word that is still changing.
  always_ff @(posedge i_debug_serial_clock) begin
    if (lrst_ff[1]) begin
      sh_out_ff <= DTT_RST_WORD;
    end else if (bit_cnt_ff == 6'h0) begin
      sh_out_ff <= resp_ff;
    end else begin
      sh_out_ff <= {sh_out_ff[30:0], 1'b0};
    end
  end
  assign o_debug_serial_out = sh_out_ff[31];

  // Serial channel, system side. A completed frame is announced by a toggle
  // that crosses through two flops; the held command word is stable by then.
  logic [2:0]  req_sync_ff;         // Toggle synchroniser plus edge stage.
  logic        ser_req;             // One-cycle command pulse.

  // The held command word is only sampled after its toggle has crossed.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      req_sync_ff <= 3'h0;
    end else begin
      req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
    end
  end
  assign ser_req = req_sync_ff[2] ^ req_sync_ff[1];
  assign ser_wr  = ser_req && (cmd_hold_ff[36] == DTT_CMD_WRITE);

  // Capture the answer to the serial command.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      resp_ff <= DTT_RST_WORD;
    end else if (ser_req) begin
      resp_ff <= reg_read(cmd_hold_ff[35:32], bp_ff, ctrl_ff, stat_word); // R02
    end
  end

  // Serial writes win over a bus write in the same cycle.
  // The bus write that loses is dropped without an error response.
  assign wr_en  = ser_wr || apb_wr;
  assign wr_idx = ser_wr ? cmd_hold_ff[35:32] : apb_idx;
  assign wr_val = ser_wr ? cmd_hold_ff[31:0] : pwdata;

  // Breakpoint bank. Each word has its own process so that the mask words
  // can take a different reset value from the match words.
  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_bp
      // Mask registers reset to all ones so every bit compares.
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          bp_ff[g] <= (g == DTT_IDX_AMASK || g == DTT_IDX_DMASK || g == DTT_IDX_PMASK)
                      ? DTT_RST_MASK : DTT_RST_WORD;
        end else if (wr_en && wr_idx == 4'(g)) begin
          bp_ff[g] <= wr_val; // R01
        end
      end
    end
  endgenerate

  // Control word. It resets with the critical level at its highest value,
  // so only the most urgent interrupts pass in emulator mode by default.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_ff <= DTT_CTRL_RST;
    end else if (wr_en && wr_idx == DTT_IDX_CTRL) begin
      ctrl_ff <= wr_val;
    end
  end

  // Comparators and trigger. Every compare is masked, and a trigger fires
  // at most once until software clears the fired flag.
  // Any of the four PC comparators, sharing one mask.
  // The PC valid strobe qualifies the whole group at once.
  always_comb begin
    pc_hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      pc_hit = pc_hit | masked_hit(i_pc, bp_ff[int'(DTT_IDX_PC0) + i],
                                   bp_ff[DTT_IDX_PMASK]); // R09
    end
    pc_hit = pc_hit && i_pc_valid;
  end
  assign ad_hit = i_bus_valid && masked_hit(i_bus_addr, bp_ff[DTT_IDX_ADDR],
                                            bp_ff[DTT_IDX_AMASK]);
  assign da_hit = i_bus_valid && masked_hit(i_bus_data, bp_ff[DTT_IDX_DATA],
                                            bp_ff[DTT_IDX_DMASK]);

  // Single level: every enabled condition at once. Two level: a PC hit
  // arms the second level, which then needs the enabled bus conditions.
  always_comb begin
    logic bus_en;
    bus_en   = ctrl_ff[DTT_CTL_AD_EN] || ctrl_ff[DTT_CTL_DA_EN];
    cond_hit = (!ctrl_ff[DTT_CTL_AD_EN] || ad_hit) && (!ctrl_ff[DTT_CTL_DA_EN] || da_hit);
    if (ctrl_ff[DTT_CTL_TWO_LV]) begin
      fire = stat_ff[DTT_ST_LEVEL1] && bus_en && cond_hit; // R03
    end else begin
      fire = (!ctrl_ff[DTT_CTL_PC_EN] || pc_hit) && cond_hit
             && (bus_en || ctrl_ff[DTT_CTL_PC_EN]); // R03
    end
    fire = fire && ctrl_ff[DTT_CTL_ARM] && !stat_ff[DTT_ST_FIRED];
  end

  // Status flags: hardware set wins over a software clear.
  // Level one is only remembered in two-level mode with the PC condition on.
  always_ff @(posedge i_clk_sys) begin
    logic [2:0] clr;
    logic [2:0] set;
    clr = (wr_en && wr_idx == DTT_IDX_STAT) ? wr_val[2:0] : 3'h0;
    set = 3'h0;
    set[DTT_ST_LEVEL1] = ctrl_ff[DTT_CTL_TWO_LV] && ctrl_ff[DTT_CTL_ARM]
                         && ctrl_ff[DTT_CTL_PC_EN] && pc_hit; // R03
    set[DTT_ST_FIRED]  = fire;
    set[DTT_ST_HALTED] = fire && !ctrl_ff[DTT_CTL_ACTION]; // R04
    if (i_rst) begin
      stat_ff <= 3'h0;
    end else begin
      stat_ff <= (stat_ff & ~clr) | set;
    end
  end

  // Halt is held until software clears it; the interrupt is a pulse.
  assign o_halt_req = stat_ff[DTT_ST_HALTED]; // R04
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_debug_irq <= 1'b0;
    end else begin
      o_debug_irq <= fire && ctrl_ff[DTT_CTL_ACTION]; // R04
    end
  end

  // In emulator mode only interrupts at or above the critical level pass.
  // Outside emulator mode every request passes unchanged.
  assign o_irq_allow = i_irq_req && (!i_emu_mode
    || i_irq_level >= LEVEL_W'(ctrl_ff[DTT_CTL_CRIT_L +: DTT_CTL_CRIT_W])); // R05

  // Trace port. Status and the trace clock leave from flops so that these
  // pins change together after each system edge.
  logic [3:0]  pst_ff;              // Registered processor status.
  logic [3:0]  nxt_pst;             // Status shown next cycle.
  logic [31:0] tdat_ff;             // Branch target being sent nibble-wise.
  logic [3:0]  tcnt_ff;             // Nibbles still to send.
  logic        tclk_ff;             // Trace clock output toggle.
  logic        combined_halt_status_ff;           // Combined halt status.

  // A halted core always shows the halt code.
  assign nxt_pst = stat_ff[DTT_ST_HALTED] ? DTT_PST_HALT : i_cpu_status;

  // Status and combined flag, both registered together.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pst_ff    <= 4'h0;
      combined_halt_status_ff <= 1'b0;
      tclk_ff   <= 1'b0;
    end else begin
      pst_ff    <= nxt_pst; // R06
      combined_halt_status_ff <= &nxt_pst; // R07
      tclk_ff   <= ~tclk_ff; // R06
    end
  end

  // Branch targets leave low nibble first; a new target restarts.
  // A branch while a target is still leaving drops the rest of the old one.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tdat_ff <= DTT_RST_WORD;
      tcnt_ff <= 4'h0;
    end else if (i_branch_valid) begin
      tdat_ff <= i_branch_target;
      tcnt_ff <= 4'(DTT_NIBBLES);
    end else if (tcnt_ff != 4'h0) begin
      tdat_ff <= {4'h0, tdat_ff[31:4]}; // R06
      tcnt_ff <= tcnt_ff - 4'h1;
    end
  end

  assign o_combined_halt_status = combined_halt_status_ff; // R08
  // Small packages keep only the combined flag and the serial channel.
  // The flops behind the trace pins are then left unused.
  generate
    if (FULL_TRACE) begin : g_trace
      assign o_processor_status_bus = pst_ff;
      assign o_trace_data_bus       = (tcnt_ff != 4'h0) ? tdat_ff[3:0] : 4'h0;
      assign o_trace_clock_out      = tclk_ff;
    end else begin : g_notrace
      assign o_processor_status_bus = 4'h0; // R08
      assign o_trace_data_bus       = 4'h0;
      assign o_trace_clock_out      = 1'b0;
    end
  endgenerate

endmodule

// ### test/dtt_debug_unit_bench.sv
module dtt_debug_unit_bench
  import dtt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk_sys, i_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [5:0]  paddr;
  logic [31:0] pwdata, prdata, i_bus_addr, i_bus_data, i_pc, i_branch_target, r, w;
  logic [2:0]  pprot, i_irq_level;
  logic        i_bus_valid, i_pc_valid, i_branch_valid, i_emu_mode, i_irq_req;
  logic [3:0]  i_cpu_status, o_processor_status_bus, o_trace_data_bus;
  logic        o_halt_req, o_debug_irq, o_irq_allow, o_trace_clock_out, o_combined_halt_status;
  logic        i_debug_serial_clock, i_debug_serial_in, o_debug_serial_out;
  int          miscompares, n_tests, c;
  dtt_debug_unit #(.FULL_TRACE(1'b1), .LEVEL_W(3)) dtt_debug_unit_inst (
    .i_clk_sys, .i_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata, .pready,
    .pslverr, .i_bus_valid, .i_bus_addr, .i_bus_data, .i_pc_valid, .i_pc, .i_cpu_status,
    .i_branch_valid, .i_branch_target, .i_emu_mode, .i_irq_req, .i_irq_level, .o_halt_req,
    .o_debug_irq, .o_irq_allow, .o_processor_status_bus, .o_trace_data_bus,
    .o_trace_clock_out, .o_combined_halt_status, .i_debug_serial_clock,
    .i_debug_serial_in, .o_debug_serial_out);
  dtt_serial_tool dtt_serial_tool_inst (.o_sclk(i_debug_serial_clock),
    .o_sdi(i_debug_serial_in), .i_sdo(o_debug_serial_out));
  initial i_clk_sys = 1'b0;
  always #4 i_clk_sys = ~i_clk_sys;
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Counts one comparison and reports a difference at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  // One APB transfer held until pready is sampled high; one idle cycle follows.
  task automatic apb(input logic wr, input logic [3:0] ix, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) begin
      miscompares++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  // Reads a word and expects it without an error response.
  task automatic rd(input logic [3:0] ix, input logic [31:0] x);
    apb(1'b0, ix, 32'h0);
    chk(r, x, "read");
    chk(e, 0, "read err");
  endtask
  // Serial frame from the tool, then back onto the system clock.
  task automatic ser(input logic [36:0] f);
    dtt_serial_tool_inst.frame(f, w);
    @(posedge i_clk_sys);
  endtask
  // One-cycle PC or bus address event; debug irq pulses are counted after it.
  task automatic obs(input logic pc, input logic [31:0] v);
    i_pc_valid <= pc;
    i_bus_valid <= !pc;
    i_pc <= v;
    i_bus_addr <= v;
    @(posedge i_clk_sys);
    i_pc_valid <= 1'b0;
    i_bus_valid <= 1'b0;
    repeat (5) begin
      @(posedge i_clk_sys);
      if (o_debug_irq === 1'b1) c++;
    end
  endtask
  initial begin
    {psel, penable, pwrite, i_bus_valid, i_pc_valid, i_branch_valid, i_emu_mode} = '0;
    {paddr, pwdata, i_bus_addr, i_bus_data, i_pc, i_branch_target, i_irq_level} = '0;
    {i_irq_req, miscompares, n_tests, c} = '0;
    pprot = 3'h1;
    i_cpu_status = 4'h5;
    i_rst = 1'b1;
    // The link side needs its own clock edges while reset is high, and exactly two
    // more after release so that its reset copy clears just before the first frame.
    fork
      dtt_serial_tool_inst.idle_clocks(3);
    join_none
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    dtt_serial_tool_inst.idle_clocks(2);
    @(posedge i_clk_sys);
    for (int i = 0; i < 11; i++) begin
      rd(4'(i), (i == 1 || i == 3 || i == 8) ? DTT_RST_MASK : (i == 9 ? DTT_CTRL_RST : 0));
    end
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, 4'(i), 32'h5a00_0000 + i);
      rd(4'(i), 32'h5a00_0000 + i);
    end
    apb(1'b1, 4'hb, 32'h1);
    chk(e, 1, "unmapped");
    pprot <= 3'h0;
    apb(1'b1, 4'h0, 32'h0);
    chk(e, 1, "user access");
    pprot <= 3'h1;
    rd(4'h0, 32'h5a00_0000);
    $display("test apb access done");
    ser({1'b1, 4'h4, 32'h1234_5678});
    rd(4'h4, 32'h1234_5678);
    ser({1'b0, 4'h8, 32'h0});
    ser({1'b0, 4'hf, 32'h0});
    chk(w, 32'h5a00_0008, "serial read");
    ser({1'b0, 4'h0, 32'h0});
    chk(w, 32'h0, "serial hole");
    $display("test serial done");
    apb(1'b1, DTT_IDX_PC0, 32'h0000_1000);
    apb(1'b1, DTT_IDX_PMASK, 32'hffff_fff0);
    apb(1'b1, DTT_IDX_CTRL, 32'h0000_0721);
    obs(1'b1, 32'h0000_1010);
    chk(o_halt_req, 0, "pc miss");
    obs(1'b1, 32'h0000_100c);
    chk(o_halt_req, 1, "pc hit");
    chk(o_processor_status_bus, DTT_PST_HALT, "halt code");
    chk(o_combined_halt_status, 1, "combined");
    apb(1'b1, DTT_IDX_STAT, 32'h7);
    chk(o_halt_req, 0, "halt cleared");
    $display("test halt trigger done");
    apb(1'b1, DTT_IDX_ADDR, 32'h2000_0000);
    apb(1'b1, DTT_IDX_AMASK, DTT_RST_MASK);
    apb(1'b1, DTT_IDX_CTRL, 32'h0000_073b);
    c = 0;
    obs(1'b0, 32'h2000_0000);
    chk(c, 0, "second level alone");
    obs(1'b1, 32'h0000_1004);
    obs(1'b0, 32'h2000_0000);
    chk(c, 1, "debug irq");
    chk(o_halt_req, 0, "no halt");
    apb(1'b1, DTT_IDX_STAT, 32'h7);
    $display("test two level done");
    apb(1'b1, DTT_IDX_DATA, 32'h0000_beef);
    apb(1'b1, DTT_IDX_DMASK, 32'h0000_ffff);
    apb(1'b1, DTT_IDX_CTRL, 32'h0000_0724);
    i_bus_data <= 32'h1234_beee;
    obs(1'b0, 32'h0);
    chk(o_halt_req, 0, "data miss");
    i_bus_data <= 32'h1234_beef;
    obs(1'b0, 32'h0);
    chk(o_halt_req, 1, "data hit");
    apb(1'b1, DTT_IDX_STAT, 32'h7);
    $display("test data trigger done");
    apb(1'b1, DTT_IDX_CTRL, 32'h0000_0300);
    i_emu_mode <= 1'b1;
    i_irq_req <= 1'b1;
    i_irq_level <= 3'h2;
    @(posedge i_clk_sys);
    chk(o_irq_allow, 0, "low level held");
    i_irq_level <= 3'h3;
    @(posedge i_clk_sys);
    chk(o_irq_allow, 1, "critical level");
    i_emu_mode <= 1'b0;
    $display("test emulator irq done");
    // Wait for the first nibble, take eight in a row, then expect the bus idle.
    i_branch_valid <= 1'b1;
    i_branch_target <= 32'h8765_4321;
    @(posedge i_clk_sys);
    i_branch_valid <= 1'b0;
    w = 32'h0;
    for (int n = 0; n < 16 && o_trace_data_bus === 4'h0; n++) begin
      @(posedge i_clk_sys);
    end
    for (int n = 0; n < 8; n++) begin
      w[4*n +: 4] = o_trace_data_bus;
      @(posedge i_clk_sys);
    end
    chk(w, 32'h8765_4321, "trace target");
    chk(o_trace_data_bus, 0, "trace idle");
    $display("test trace done");
    close_out();
  end
endmodule
bind dtt_debug_unit dtt_debug_unit_chk dtt_debug_unit_chk_inst (.i_clk_sys, .i_rst, .psel,
  .penable, .paddr, .pprot, .pready, .pslverr, .i_irq_req, .i_emu_mode, .o_halt_req,
  .o_debug_irq, .o_irq_allow, .o_processor_status_bus, .o_trace_clock_out,
  .o_combined_halt_status);

// ### test/dtt_debug_unit_chk.sv
module dtt_debug_unit_chk
  import dtt_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [5:0] paddr,
  input wire logic [2:0] pprot,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       i_irq_req,
  input wire logic       i_emu_mode,
  input wire logic       o_halt_req,
  input wire logic       o_debug_irq,
  input wire logic       o_irq_allow,
  input wire logic [3:0] o_processor_status_bus,
  input wire logic       o_trace_clock_out,
  input wire logic       o_combined_halt_status
);
  timeunit 1ns;
  timeprecision 100ps;
  // All checks use the system clock and rest while reset is high.
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // Access phase of an APB transfer.
  sequence s_acc;
    psel && penable;
  endsequence
  // Access phase of a privileged, aligned request to a mapped word.
  sequence s_good;
    s_acc ##0 (pprot[0] && paddr[1:0] == 2'h0 && paddr[5:2] <= 4'ha);
  endsequence
  property p_ready;
    s_acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_priv;
    s_acc ##0 !pprot[0] |-> pslverr;
  endproperty
  a_priv: assert property (p_priv) else $error("user access accepted");
  property p_hole;
    s_acc ##0 paddr[5:2] > 4'ha |-> pslverr;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped access accepted");
  property p_good;
    s_good |-> !pslverr;
  endproperty
  a_good: assert property (p_good) else $error("good access refused");
  property p_all;
    o_combined_halt_status == (&o_processor_status_bus);
  endproperty
  a_all: assert property (p_all) else $error("combined output wrong");
  property p_halt;
    o_halt_req |-> ##[0:2] o_processor_status_bus == DTT_PST_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("halt without halt code");
  property p_pulse;
    o_debug_irq |=> !o_debug_irq;
  endproperty
  a_pulse: assert property (p_pulse) else $error("debug irq too long");
  property p_allow;
    !i_emu_mode |-> o_irq_allow == i_irq_req;
  endproperty
  a_allow: assert property (p_allow) else $error("irq gating wrong");
  property p_tclk;
    !$past(i_rst) |-> o_trace_clock_out != $past(o_trace_clock_out);
  endproperty
  a_tclk: assert property (p_tclk) else $error("trace clock stuck");
endmodule

// ### test/dtt_serial_tool.sv
module dtt_serial_tool (
  output logic      o_sclk,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // The link clock rests low outside frames.
  initial begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // Clock pulses so the link side sees reset.
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #15 o_sclk = 1'b1;
      #15 o_sclk = 1'b0;
    end
  endtask
  // One frame, MSB first; the word shifted out by the device is collected meanwhile.
  task automatic frame(input logic [36:0] f, output logic [31:0] r);
    r = 32'h0;
    for (int i = 36; i >= 0; i--) begin
      o_sdi = f[i];
      #15 o_sclk = 1'b1;
      #14 if (i >= 5) r[i-5] = i_sdo;
      #1 o_sclk = 1'b0;
    end
    // Released line shows the inverse of its last value; the gap lets the request land.
    o_sdi = ~o_sdi;
    #200;
  endtask
endmodule
